/* core/asm_port.sv */
// Asynchronous static memory port: strobes, selects and byte lanes to a 16-bit memory
`timescale 1ns/1ns
module asm_port
    import asm_pkg::*;
#(
    parameter int ADDR_W = ASM_ADDR_W,
    parameter int DATA_W = ASM_DATA_W,
    parameter int BANKS = ASM_BANKS,
    parameter int SETUP_CYC = ASM_SETUP_CYC,
    parameter int ACCESS_CYC = ASM_ACCESS_CYC,
    parameter int HOLD_CYC = ASM_HOLD_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    // User request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [$clog2(BANKS)-1:0] req_bank,
    input wire logic [1:0] req_lanes,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic rd_valid,
    output logic [DATA_W-1:0] rd_data,
    // Memory pins
    output logic [ADDR_W-1:0] memory_address_bus,
    input wire logic [DATA_W-1:0] memory_data_bus_in,
    output logic [DATA_W-1:0] memory_data_bus_out,
    output logic memory_data_bus_oe_n,
    output logic [BANKS-1:0] memory_bank_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic output_enable_n,
    output logic [1:0] byte_lane_enable_n,
    input wire logic memory_ready_in
);
    // Refuse settings the logic cannot serve
    if (DATA_W != 16) begin : g_bad_width
        $error("asm_port: data bus must be 16 bits wide");
    end
    if (BANKS < 2 || SETUP_CYC < 1 || ACCESS_CYC < 1 || HOLD_CYC < 1) begin : g_bad_timing
        $error("asm_port: need two banks and at least one cycle per phase");
    end
    if (SETUP_CYC > 255 || ACCESS_CYC > 255 || HOLD_CYC > 255) begin : g_bad_count
        $error("asm_port: phase length exceeds counter range");
    end

    localparam logic [ASM_CNT_W-1:0] SETUP_LAST = ASM_CNT_W'(SETUP_CYC - 1);
    localparam logic [ASM_CNT_W-1:0] ACCESS_LAST = ASM_CNT_W'(ACCESS_CYC - 1);
    localparam logic [ASM_CNT_W-1:0] HOLD_LAST = ASM_CNT_W'(HOLD_CYC - 1);

    typedef struct packed {
        asm_state_t state;
        logic [ASM_CNT_W-1:0] cnt;
        logic write;
        logic req_ready;
        logic rd_valid;
        logic [DATA_W-1:0] rd_data;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic doe_n;
        logic [BANKS-1:0] sel_n;
        logic rd_n;
        logic wr_n;
        logic oe_n;
        logic [1:0] lanes_n;
    } asm_port_t;

    asm_port_t port_reg;
    asm_port_t port_next;
    logic [1:0] rst_pipe_reg;
    logic rst_core_n;
    asm_rdy_if rdy_if ();

    // Active-low lane enables from a lane request; reads and full writes use both
    function automatic logic [1:0] asm_lane_decode(input logic wr, input logic [1:0] lanes);
        logic [1:0] res;
        res = 2'h0;
        if (wr) begin
            case (lanes)
                ASM_LANE_HIGH: res = 2'h1;
                ASM_LANE_LOW: res = 2'h2;
                default: res = 2'h0;
            endcase
        end
        return res;
    endfunction

    // Active-low one-hot select for the addressed bank
    function automatic logic [BANKS-1:0] asm_bank_decode(input logic [$clog2(BANKS)-1:0] b);
        logic [BANKS-1:0] res;
        res = '1;
        res[b] = 1'b0;
        return res;
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_core_n = rst_pipe_reg[1];

    // Ready synchroniser
    asm_ready_sync u_ready_sync (
        .clock(clock),
        .rst_n(rst_core_n),
        .async_in(memory_ready_in),
        .sync_out(rdy_if.src)
    );

    // Phase sequencing and pin levels
    always_comb begin
        port_next = port_reg;
        port_next.rd_valid = 1'b0;
        case (port_reg.state)
            ASM_IDLE: begin
                if (req_valid && port_reg.req_ready) begin
                    port_next.state = ASM_SETUP;
                    port_next.cnt = SETUP_LAST;
                    port_next.req_ready = 1'b0;
                    port_next.write = req_write;
                    port_next.addr = req_addr;
                    port_next.dout = req_wdata;
                    port_next.doe_n = ~req_write;
                    port_next.sel_n = asm_bank_decode(req_bank);
                    port_next.lanes_n = asm_lane_decode(req_write, req_lanes);
                    port_next.oe_n = req_write;
                end
            end
            ASM_SETUP: begin
                if (port_reg.cnt == '0) begin
                    port_next.state = ASM_ACCESS;
                    port_next.cnt = ACCESS_LAST;
                    port_next.rd_n = port_reg.write;
                    port_next.wr_n = ~port_reg.write;
                end else begin
                    port_next.cnt = port_reg.cnt - 1'b1;
                end
            end
            ASM_ACCESS: begin
                if (port_reg.cnt != '0) begin
                    port_next.cnt = port_reg.cnt - 1'b1;
                end else if (rdy_if.level) begin
                    // Ready seen after the minimum access time: close the strobe
                    port_next.state = ASM_HOLD;
                    port_next.cnt = HOLD_LAST;
                    port_next.rd_n = ASM_STROBE_IDLE;
                    port_next.wr_n = ASM_STROBE_IDLE;
                    if (!port_reg.write) begin
                        port_next.rd_data = memory_data_bus_in;
                    end
                end
            end
            ASM_HOLD: begin
                if (port_reg.cnt == '0) begin
                    port_next.state = ASM_IDLE;
                    port_next.req_ready = 1'b1;
                    port_next.rd_valid = ~port_reg.write;
                    port_next.doe_n = ASM_STROBE_IDLE;
                    port_next.sel_n = '1;
                    port_next.oe_n = ASM_STROBE_IDLE;
                    port_next.lanes_n = ASM_BYTES_OFF;
                end else begin
                    port_next.cnt = port_reg.cnt - 1'b1;
                end
            end
            default: begin
                port_next.state = ASM_IDLE;
                port_next.req_ready = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock or negedge rst_core_n) begin
        if (!rst_core_n) begin
            port_reg.state <= ASM_IDLE;
            port_reg.cnt <= '0;
            port_reg.write <= 1'b0;
            port_reg.req_ready <= 1'b1;
            port_reg.rd_valid <= 1'b0;
            port_reg.rd_data <= '0;
            port_reg.addr <= '0;
            port_reg.dout <= '0;
            port_reg.doe_n <= ASM_STROBE_IDLE;
            port_reg.sel_n <= '1;
            port_reg.rd_n <= ASM_STROBE_IDLE;
            port_reg.wr_n <= ASM_STROBE_IDLE;
            port_reg.oe_n <= ASM_STROBE_IDLE;
            port_reg.lanes_n <= ASM_BYTES_OFF;
        end else begin
            port_reg <= port_next;
        end
    end

    // Outputs straight from the state register
    assign req_ready = port_reg.req_ready;
    assign rd_valid = port_reg.rd_valid;
    assign rd_data = port_reg.rd_data;
    assign memory_address_bus = port_reg.addr;
    assign memory_data_bus_out = port_reg.dout;
    assign memory_data_bus_oe_n = port_reg.doe_n;
    assign memory_bank_select_n = port_reg.sel_n;
    assign read_strobe_n = port_reg.rd_n;
    assign write_strobe_n = port_reg.wr_n;
    assign output_enable_n = port_reg.oe_n;
    assign byte_lane_enable_n = port_reg.lanes_n;
endmodule

/* core/asm_ready_sync.sv */
// Two-stage synchroniser for the memory ready input
`timescale 1ns/1ns
module asm_ready_sync
    import asm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic async_in,
    asm_rdy_if.src sync_out
);
    typedef struct packed {
        logic meta;
        logic stable;
    } asm_sync_t;

    asm_sync_t sync_reg;
    asm_sync_t sync_next;

    // Shift the raw level through two stages
    always_comb begin
        sync_next.meta = async_in;
        sync_next.stable = sync_reg.meta;
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out.level = sync_reg.stable;
endmodule

/* pkg/asm_pkg.sv */
// Shared constants and types for the asynchronous static memory port
package asm_pkg;
    // Bus widths and bank count
    localparam int ASM_ADDR_W = 24;
    localparam int ASM_DATA_W = 16;
    localparam int ASM_BANKS = 4;
    // Phase lengths in clock cycles (clock is 20 MHz, 50 ns period)
    localparam int ASM_SETUP_CYC = 1;
    localparam int ASM_ACCESS_CYC = 2;
    localparam int ASM_HOLD_CYC = 1;
    localparam int ASM_CNT_W = 8;
    // Reset values of pin levels
    localparam logic ASM_STROBE_IDLE = 1'h1;
    localparam logic [1:0] ASM_BYTES_OFF = 2'h3;
    // Byte lane request encodings
    localparam logic [1:0] ASM_LANE_LOW = 2'h1;
    localparam logic [1:0] ASM_LANE_HIGH = 2'h2;
    localparam logic [1:0] ASM_LANE_BOTH = 2'h3;
    // Access phases, Gray coded along idle, setup, access, hold
    typedef enum logic [1:0] {
        ASM_IDLE = 2'h0,
        ASM_SETUP = 2'h1,
        ASM_ACCESS = 2'h3,
        ASM_HOLD = 2'h2
    } asm_state_t;
endpackage

/* pkg/asm_rdy_if.sv */
// Carrier for the synchronised ready level between the port and its synchroniser
`timescale 1ns/1ns
interface asm_rdy_if;
    logic level;
    modport src (output level);
    modport dst (input level);
endinterface

/* tb/asm_mem_model.sv */
// Behavioural 16-bit asynchronous memory with a slow mode
`timescale 1ns/1ns
module asm_mem_model (
    input wire logic clock,
    input wire logic slow,
    input wire logic [3:0] select_n,
    input wire logic output_enable_n,
    input wire logic write_strobe_n,
    input wire logic [1:0] lane_n,
    input wire logic [23:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    output logic ready
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0;
    int cnt = 0;
    // Ready withheld for the first six cycles of each selected access in slow mode
    assign ready = !(slow && !(&select_n) && cnt < 6);
    // Data only while enabled and selected, else a changing pattern
    assign rdata = (!output_enable_n && !(&select_n)) ? mem[addr[3:0]] : ~last;
    // Stall count and byte-wise writes under the strobe
    always @(posedge clock) begin
        last <= (^rdata === 1'bx) ? last : rdata; // Keep a known pattern
        cnt <= (&select_n) ? 0 : cnt + 1;
        if (!write_strobe_n && !lane_n[0]) mem[addr[3:0]][7:0] <= wdata[7:0];
        if (!write_strobe_n && !lane_n[1]) mem[addr[3:0]][15:8] <= wdata[15:8];
    end
endmodule

/* tb/asm_port_checker.sv */
// Pin-level assertions for the static memory port
`timescale 1ns/1ns
module asm_port_checker #(
    parameter int BANKS = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic [$clog2(BANKS)-1:0] req_bank,
    input wire logic [1:0] req_lanes,
    input wire logic [BANKS-1:0] memory_bank_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [1:0] byte_lane_enable_n,
    input wire logic memory_ready_in
);
    logic take;
    // Request accepted on this edge
    assign take = req_valid && req_ready;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_upper_lane: assert property (take && req_write && req_lanes == 2'h2
        |=> byte_lane_enable_n == 2'h1) else $error("upper byte lanes wrong");
    a_lower_lane: assert property (take && req_write && req_lanes == 2'h1
        |=> byte_lane_enable_n == 2'h2) else $error("lower byte lanes wrong");
    a_oe_setup: assert property (take && !req_write
        |=> !output_enable_n && read_strobe_n) else $error("output enable late");
    a_read_strobe: assert property (take && !req_write
        |=> ##1 !read_strobe_n) else $error("read strobe late");
    a_write_hold: assert property ($fell(write_strobe_n)
        |-> !write_strobe_n[*2]) else $error("write strobe too short");
    a_write_close: assert property ($rose(write_strobe_n)
        |-> !(&memory_bank_select_n) ##1 (&memory_bank_select_n)) else $error("write close wrong");
    a_stall_hold: assert property ((!memory_ready_in)[*3] ##0 !write_strobe_n
        |=> !write_strobe_n) else $error("write ended while not ready");
    a_bank_select: assert property (take
        |=> memory_bank_select_n == ~(BANKS'(1) << $past(req_bank))) else $error("bad select");
    a_sync_delay: assert property ((!memory_ready_in)[*2] ##1 memory_ready_in
        ##0 !read_strobe_n |=> !read_strobe_n[*2]) else $error("ready used too early");
endmodule
bind asm_port asm_port_checker #(.BANKS(BANKS)) chk_u (.clock(clock), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_bank(req_bank), .req_lanes(req_lanes), .memory_bank_select_n(memory_bank_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n), .byte_lane_enable_n(byte_lane_enable_n),
    .memory_ready_in(memory_ready_in));

/* tb/asm_port_tb.sv */
// Self-checking bench for the static memory port
`timescale 1ns/1ns
module asm_port_tb;
    import asm_pkg::*;
    logic clock = 0, rst_n = 0, req_valid = 0, req_write = 0, slow = 0;
    logic [23:0] req_addr = 0, addr;
    logic [1:0] req_bank = 0, req_lanes = 0, lane_n, lane_seen;
    logic [15:0] req_wdata = 0, rd_data, mem_in, mem_out;
    logic [3:0] sel_n;
    logic req_ready, rd_valid, rs_n, ws_n, oe_n, rdy, doe_n;
    int err_total = 0, check_count = 0, lat;
    asm_port dut_u (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_bank(req_bank), .req_lanes(req_lanes), .req_wdata(req_wdata),
        .rd_valid(rd_valid), .rd_data(rd_data), .memory_address_bus(addr),
        .memory_data_bus_in(mem_in), .memory_data_bus_out(mem_out),
        .memory_data_bus_oe_n(doe_n), .memory_bank_select_n(sel_n), .read_strobe_n(rs_n),
        .write_strobe_n(ws_n), .output_enable_n(oe_n), .byte_lane_enable_n(lane_n),
        .memory_ready_in(rdy));
    asm_mem_model mem_u (.clock(clock), .slow(slow), .select_n(sel_n),
        .output_enable_n(oe_n), .write_strobe_n(ws_n), .lane_n(lane_n), .addr(addr),
        .wdata(mem_out), .rdata(mem_in), .ready(rdy));
    // Free-running clock, 50 ns period
    initial begin
        forever #25 clock = ~clock;
    end
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One access from an idle falling edge until the port is idle again
    task automatic acc(logic w, logic [1:0] b, logic [1:0] ln, logic [23:0] a,
        logic [15:0] d);
        req_valid = 1;
        req_write = w;
        req_bank = b;
        req_lanes = ln;
        req_addr = a;
        req_wdata = d;
        @(negedge clock);
        req_valid = 0;
        lane_seen = lane_n;
        check("data drive", {15'h0, doe_n}, {15'h0, !w});
        lat = 0;
        while (req_ready !== 1'b1) begin
            @(negedge clock);
            lat++;
            if (lat > 40) begin
                err_total++;
                results();
            end
        end
        check("rd_valid", {15'h0, rd_valid}, {15'h0, !w});
    endtask
    // Whole word, then upper and lower byte writes, read back on another bank
    task automatic t_lanes();
        acc(1, 2'h0, ASM_LANE_BOTH, 24'h5, 16'h1234);
        acc(1, 2'h1, ASM_LANE_HIGH, 24'h5, 16'hab00);
        check("upper lanes", {14'h0, lane_seen}, 16'h1);
        acc(1, 2'h2, ASM_LANE_LOW, 24'h5, 16'h00cd);
        check("lower lanes", {14'h0, lane_seen}, 16'h2);
        acc(0, 2'h3, ASM_LANE_BOTH, 24'h5, 16'h0);
        check("merged word", rd_data, 16'habcd);
    endtask
    // Slow memory stretches both a write and a read
    task automatic t_slow();
        slow = 1;
        acc(1, 2'h2, ASM_LANE_BOTH, 24'h9, 16'h5a5a);
        check("slow write", {15'h0, lat > 6}, 16'h1);
        acc(0, 2'h1, ASM_LANE_BOTH, 24'h9, 16'h0);
        check("slow read", rd_data, 16'h5a5a);
        check("slow stall", {15'h0, lat > 6}, 16'h1);
        slow = 0;
    endtask
    // Back-to-back reads of two addresses
    task automatic t_b2b();
        acc(0, 2'h0, ASM_LANE_BOTH, 24'h9, 16'h0);
        check("first read", rd_data, 16'h5a5a);
        acc(0, 2'h0, ASM_LANE_BOTH, 24'h5, 16'h0);
        check("second read", rd_data, 16'habcd);
    endtask
    // Reset, then the scenarios
    initial begin
        repeat (4) @(negedge clock);
        rst_n = 1;
        repeat (3) @(negedge clock);
        t_lanes();
        t_slow();
        t_b2b();
        results();
    end
endmodule
